// [verilog/omcs_pkg.sv]
// package for the optical module control/status block
// assumes a single 200 MHz clock domain
`default_nettype none

package omcs_pkg;
  // diagnostic page device address and status byte offset
  localparam logic [7:0] OMCS_PAGE_ADDR   = 8'ha2;
  localparam logic [7:0] OMCS_CTRL_OFFSET = 8'h6e;
  // field positions in the control/status byte
  localparam int OMCS_BIT_LOS      = 1;
  localparam int OMCS_BIT_FAULT    = 2;
  localparam int OMCS_BIT_SW_RATE  = 3;
  localparam int OMCS_BIT_RATE     = 4;
  localparam int OMCS_BIT_SW_OFF   = 6;
  localparam int OMCS_BIT_OFF      = 7;
  // writable bits mask and reset value
  localparam logic [7:0] OMCS_WR_MASK    = 8'h48;
  localparam logic [7:0] OMCS_CTRL_RESET = 8'h00;
  // host spacing between shut-off assertions
  localparam int OMCS_CLK_MHZ         = 200;
  localparam int OMCS_SHUT_SPACING_MS = 10;
  localparam int OMCS_SHUT_SPACING_CYC =
    OMCS_SHUT_SPACING_MS * 1000 * OMCS_CLK_MHZ;
endpackage

`default_nettype wire

// [verilog/omcs_ctrl.sv]
// optical module control/status logic with status byte access
// assumes pins arrive asynchronously; byte port is on clk
`timescale 1ns/1ps
`default_nettype none

module omcs_ctrl (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic       shut_off_pin,
  input  wire logic       shut_off_driven,
  input  wire logic       rate_sel_pin,
  input  wire logic       rate_sel_driven,
  input  wire logic       laser_fault_det,
  input  wire logic       unsafe_power_det,
  input  wire logic       rx_signal_bad,
  input  wire logic [7:0] page_dev_addr,
  input  wire logic [7:0] byte_addr,
  input  wire logic       byte_wr,
  input  wire logic       byte_rd,
  input  wire logic [7:0] byte_wdata,
  output logic      [7:0] byte_rdata,
  output logic            byte_hit,
  output logic            tx_enable,
  output logic            high_rate_mode,
  output logic            tx_fault_o,
  output logic            tx_fault_oe,
  output logic            receive_signal_missing
);
  import omcs_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic [1:0] off_s;
    logic [1:0] rate_s;
    logic [1:0] flt_s;
    logic [1:0] uns_s;
    logic [1:0] los_s;
    logic       off_d;
    logic       sw_off;
    logic       sw_rate;
    logic       fault;
    logic       tx_en;
    logic       hi_rate;
    logic       flt_o;
    logic       los_o;
    logic [7:0] rdata;
    logic       hit;
  } omcs_state_type;

  omcs_state_type st;
  omcs_state_type next_st;

  // select of the status byte on the diagnostic page
  function automatic logic omcs_sel(input logic [7:0] dev,
                                    input logic [7:0] off);
    omcs_sel = (dev == OMCS_PAGE_ADDR) && (off == OMCS_CTRL_OFFSET);
  endfunction

  logic       hw_off;
  logic       hw_rate;
  logic       off_eff;
  logic       rate_eff;
  logic [7:0] status_byte;

  // ==========================================================
  // combinational next state
  always_comb begin
    next_st = st;
    // two-flop synchronisers on pins
    next_st.off_s  = {st.off_s[0], shut_off_pin | ~shut_off_driven};
    next_st.rate_s = {st.rate_s[0], rate_sel_pin & rate_sel_driven};
    next_st.flt_s  = {st.flt_s[0], laser_fault_det};
    next_st.uns_s  = {st.uns_s[0], unsafe_power_det};
    next_st.los_s  = {st.los_s[0], rx_signal_bad};
    hw_off   = st.off_s[1];
    hw_rate  = st.rate_s[1];
    next_st.off_d = hw_off;
    off_eff  = hw_off | st.sw_off;
    rate_eff = hw_rate | st.sw_rate;
    // fault latch: set wins, cleared only by shut-off toggle
    if (st.flt_s[1] || st.uns_s[1]) begin
      next_st.fault = 1'b1;
    end else if (hw_off != st.off_d) begin
      next_st.fault = 1'b0;
    end
    // transmitter enable: off on shut-off or latched fault
    next_st.tx_en   = ~off_eff & ~next_st.fault & ~st.uns_s[1];
    next_st.hi_rate = rate_eff;
    next_st.flt_o   = next_st.fault;
    next_st.los_o   = st.los_s[1];
    // status byte image, unassigned bits zero
    status_byte = 8'h00;
    status_byte[OMCS_BIT_OFF]     = off_eff;
    status_byte[OMCS_BIT_SW_OFF]  = st.sw_off;
    status_byte[OMCS_BIT_RATE]    = rate_eff;
    status_byte[OMCS_BIT_SW_RATE] = st.sw_rate;
    status_byte[OMCS_BIT_FAULT]   = st.fault;
    status_byte[OMCS_BIT_LOS]     = st.los_s[1];
    // byte access: only control bits take writes
    next_st.hit = 1'b0;
    if (omcs_sel(page_dev_addr, byte_addr)) begin
      if (byte_wr) begin
        next_st.sw_off  = byte_wdata[OMCS_BIT_SW_OFF];
        next_st.sw_rate = byte_wdata[OMCS_BIT_SW_RATE];
        next_st.hit     = 1'b1;
      end
      if (byte_rd) begin
        next_st.rdata = status_byte;
        next_st.hit   = 1'b1;
      end
    end
  end

  // ==========================================================
  // state register with clock enable and sync reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st         <= '0;
      st.off_s   <= 2'b11;
      st.off_d   <= 1'b1;
      st.sw_off  <= OMCS_CTRL_RESET[OMCS_BIT_SW_OFF];
      st.sw_rate <= OMCS_CTRL_RESET[OMCS_BIT_SW_RATE];
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs from flops, except tx_fault_o tied low
  assign byte_rdata             = st.rdata;
  assign byte_hit               = st.hit;
  assign tx_enable              = st.tx_en;
  assign high_rate_mode         = st.hi_rate;
  assign tx_fault_o             = 1'b0;       // open collector pulls low only
  assign tx_fault_oe            = ~st.flt_o;  // released = high via pull-up
  assign receive_signal_missing = st.los_o;
endmodule

`default_nettype wire

// [sim/omcs_ctrl_monitor.sv]
// checker on the control/status block ports
// assumes clk_en held high
`timescale 1ns/1ps
`default_nettype none
module omcs_ctrl_monitor (
  input wire logic clk, rst_n, clk_en, shut_off_pin, shut_off_driven,
  input wire logic rate_sel_pin, rate_sel_driven, laser_fault_det,
  input wire logic unsafe_power_det, rx_signal_bad, byte_wr, byte_rd,
  input wire logic [7:0] page_dev_addr, byte_addr, byte_rdata,
  input wire logic byte_hit, tx_enable, high_rate_mode, tx_fault_oe,
  input wire logic receive_signal_missing
);
  logic [3:0] hist;
  logic       off_in;
  logic       sel;
  // shut-off level as seen, recent history
  assign off_in = shut_off_pin | ~shut_off_driven;
  assign sel = clk_en && page_dev_addr == 8'ha2 && byte_addr == 8'h6e;
  always_ff @(posedge clk) begin
    hist <= {hist[2:0], off_in};
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  AST_HIT: assert property (sel && (byte_wr || byte_rd) |=> byte_hit)
    else $error("no hit");
  AST_MISS: assert property (clk_en && !(sel && (byte_wr || byte_rd))
    |=> !byte_hit)
    else $error("stray hit");
  AST_OFF: assert property (off_in[*4] |=> !tx_enable)
    else $error("tx on");
  AST_UNDRV: assert property ((!shut_off_driven)[*4] |=> !tx_enable)
    else $error("undriven tx on");
  AST_FLT: assert property ((laser_fault_det || unsafe_power_det)[*4]
    |=> !tx_enable && !tx_fault_oe)
    else $error("fault ignored");
  AST_HOLD: assert property (!tx_fault_oe && off_in == hist[0]
    && (hist == 4'h0 || hist == 4'hf) |=> !tx_fault_oe)
    else $error("fault dropped");
  AST_RATE: assert property ((rate_sel_pin && rate_sel_driven)[*4]
    |=> high_rate_mode)
    else $error("rate low");
  AST_LOS: assert property (rx_signal_bad[*4] |=> receive_signal_missing)
    else $error("loss missed");
  AST_RSV: assert property (byte_hit |-> !byte_rdata[5] && !byte_rdata[0])
    else $error("spare bit set");
endmodule
bind omcs_ctrl omcs_ctrl_monitor i_omcs_ctrl_monitor (.*);
`default_nettype wire

// [sim/omcs_host_model.sv]
// host board model: shut-off drive, fault pull-up
// assumes bench commands the host levels
`timescale 1ns/1ps
`default_nettype none
module omcs_host_model (
  input  wire logic off_req,
  input  wire logic float_off,
  input  wire logic tx_fault_o,
  input  wire logic tx_fault_oe,
  output logic      shut_off_pin,
  output logic      shut_off_driven,
  output logic      fault_line
);
  // released pin floats up to the pull-up level, grounded when unused
  // shut-off spacing is a host duty, compressed here for run length
  assign shut_off_pin    = float_off ? 1'b1 : off_req;
  assign shut_off_driven = ~float_off;
  assign fault_line      = tx_fault_oe ? tx_fault_o : 1'b1;
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// bench for the control/status block
// assumes host model and checker in sim/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 0, rst_n = 0, clk_en = 1, off_req = 0, float_off = 0;
  logic rate_sel_pin = 0, rate_sel_driven = 1, laser_fault_det = 0;
  logic unsafe_power_det = 0, rx_signal_bad = 0, byte_wr = 0, byte_rd = 0;
  logic [7:0] page_dev_addr = 8'ha2, byte_addr = 8'h6e, byte_wdata = 8'h00;
  logic [7:0] byte_rdata;
  logic byte_hit, tx_enable, high_rate_mode, tx_fault_o, tx_fault_oe;
  logic receive_signal_missing, shut_off_pin, shut_off_driven, fault_line;
  int num_errors = 0, n_compared = 0;
  always #2.5 clk = ~clk;
  omcs_ctrl i_omcs_ctrl (.*);
  omcs_host_model i_omcs_host_model (.*);
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one byte access, hit and read data looked at next cycle
  task automatic acc(input logic w, input logic [7:0] dev, d, exp);
    byte_wr = w;
    byte_rd = !w;
    page_dev_addr = dev;
    byte_wdata = d;
    step(1);
    byte_wr = 0;
    byte_rd = 0;
    chk(byte_hit, dev == 8'ha2);
    if (!w && dev == 8'ha2) chk(byte_rdata, exp);
  endtask
  // let pins settle, then outputs and status byte
  task automatic look(input logic [7:0] exp_byte, input logic [3:0] exp_out);
    step(4);
    chk({tx_enable, high_rate_mode, fault_line, receive_signal_missing},
        exp_out);
    acc(1'b0, 8'ha2, 8'h00, exp_byte);
  endtask
  task automatic close_out;
    if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    step(8);
    rst_n = 1;
    look(8'h00, 4'h8);
    acc(1'b1, 8'ha2, 8'hff, 8'h00);
    look(8'hd8, 4'h4);
    acc(1'b1, 8'ha0, 8'h00, 8'h00);
    look(8'hd8, 4'h4);
    acc(1'b1, 8'ha2, 8'h00, 8'h00);
    look(8'h00, 4'h8);
    off_req = 1;
    look(8'h80, 4'h0);
    off_req = 0;
    float_off = 1;
    look(8'h80, 4'h0);
    float_off = 0;
    rate_sel_pin = 1;
    look(8'h10, 4'hc);
    rate_sel_driven = 0;
    look(8'h00, 4'h8);
    rx_signal_bad = 1;
    look(8'h02, 4'h9);
    rx_signal_bad = 0;
    laser_fault_det = 1;
    step(4);
    laser_fault_det = 0;
    look(8'h04, 4'h2);
    off_req = 1;
    step(4);
    off_req = 0;
    look(8'h00, 4'h8);
    unsafe_power_det = 1;
    look(8'h04, 4'h2);
    close_out;
  end
  // cut a hang short
  initial begin
    #5000;
    num_errors++;
    close_out;
  end
endmodule
`default_nettype wire
